/* File: pek_pkg.sv */
package pek_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [5:0] IDX_IFACE_WR   = 6'h07;
  localparam logic [5:0] IDX_IFACE_SET  = 6'h08;
  localparam logic [5:0] IDX_IFACE_CLR  = 6'h09;
  localparam logic [5:0] IDX_RISE_WR    = 6'h0D;
  localparam logic [5:0] IDX_RISE_SET   = 6'h0E;
  localparam logic [5:0] IDX_RISE_CLR   = 6'h0F;
  localparam logic [5:0] IDX_FALL_WR    = 6'h10;
  localparam logic [5:0] IDX_FALL_SET   = 6'h11;
  localparam logic [5:0] IDX_FALL_CLR   = 6'h12;
  localparam logic [5:0] IDX_STATUS     = 6'h13;
  localparam logic [5:0] IDX_LATCH      = 6'h14;
  localparam logic [5:0] IDX_DEBUG      = 6'h15;
  localparam logic [5:0] IDX_SCRATCH_WR = 6'h16;
  localparam logic [5:0] IDX_SCRATCH_SET = 6'h17;
  localparam logic [5:0] IDX_SCRATCH_CLR = 6'h18;
  localparam logic [5:0] IDX_KIT_WR     = 6'h19;
  localparam logic [5:0] IDX_KIT_SET    = 6'h1A;
  localparam logic [5:0] IDX_KIT_CLR    = 6'h1B;

  // Access kind within a write/set/clear triple
  localparam logic [1:0] ACC_WRITE = 2'h0;
  localparam logic [1:0] ACC_SET   = 2'h1;
  localparam logic [1:0] ACC_CLEAR = 2'h2;

  // Event source bit positions
  localparam int SRC_HOST_DETACH = 0;
  localparam int SRC_VBUS_VALID  = 1;
  localparam int SRC_SESS_VALID  = 2;
  localparam int SRC_SESS_END    = 3;
  localparam int SRC_ID_GROUNDED = 4;
  localparam int SRC_COUNT       = 5;

  // Writable field masks
  localparam logic [7:0] MASK_ENABLE  = 8'h1F;
  localparam logic [7:0] MASK_SCRATCH = 8'hFF;
  localparam logic [7:0] MASK_KIT     = 8'h0E;
  localparam logic [7:0] MASK_IFACE   = 8'h04;

  // Field positions in the kit and interface control registers
  localparam int KIT_ID_PULLDOWN = 1;
  localparam int KIT_TX_ROUTE    = 2;
  localparam int KIT_RX_ROUTE    = 3;
  localparam int IFACE_KIT_MODE  = 2;

  // Reset values
  localparam logic [7:0] RST_ENABLE  = 8'h1F;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] RST_KIT     = 8'h00;
  localparam logic [7:0] RST_IFACE   = 8'h00;

  // Synchronised pin vector layout
  localparam int PIN_LINE0     = 5;
  localparam int PIN_LINE1     = 6;
  localparam int PIN_HOST_MODE = 7;
  localparam int PIN_KIT_EXIT  = 8;
  localparam int PIN_DATA0     = 9;
  localparam int PIN_DPLUS     = 10;
  localparam int PIN_COUNT     = 11;

endpackage

/* File: pek_event_kit_regs.sv */
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
module pek_event_kit_regs (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        host_detach_in,
  input  wire logic        vbus_valid_in,
  input  wire logic        session_valid_level,
  input  wire logic        session_end_level,
  input  wire logic        id_grounded,
  input  wire logic        host_mode_in,
  input  wire logic [1:0]  line_state_in,
  input  wire logic        kit_exit_in,
  input  wire logic        data0_in,
  input  wire logic        dplus_in,
  output logic             id_pin_pulldown_drive,
  output logic             id_pin_out,
  output logic             id_pin_oe,
  output logic             dminus_out,
  output logic             dminus_oe,
  output logic             data1_out,
  output logic             data1_oe,
  output logic             kit_interface_mode
);

  // Applies a write, set or clear access to one register of a triple
  function automatic logic [7:0] pek_apply(
    input logic [7:0] cur,
    input logic [5:0] idx,
    input logic [5:0] base,
    input logic [7:0] data,
    input logic [7:0] mask
  );
    logic [7:0] res;
    logic [5:0] off;
    res = cur;
    off = idx - base;
    if (idx >= base && off <= 6'(pek_pkg::ACC_CLEAR))
    begin
      unique case (off[1:0])
        pek_pkg::ACC_WRITE: res = (cur & ~mask) | (data & mask);
        pek_pkg::ACC_SET:   res = cur | (data & mask);
        pek_pkg::ACC_CLEAR: res = cur & ~(data & mask);
        default:            res = cur;
      endcase
    end
    return res;
  endfunction

  // True when the index lies in a three-address readable triple
  function automatic logic pek_in_triple(
    input logic [5:0] idx,
    input logic [5:0] base
  );
    logic [5:0] off;
    off = idx - base;
    return (idx >= base) && (off <= 6'(pek_pkg::ACC_CLEAR));
  endfunction

  logic [pek_pkg::PIN_COUNT-1:0] pin_s1_r;
  logic [pek_pkg::PIN_COUNT-1:0] pin_s2_r;
  logic [pek_pkg::SRC_COUNT-1:0] src_prev_r;
  logic [pek_pkg::SRC_COUNT-1:0] src_now;
  logic [pek_pkg::SRC_COUNT-1:0] events;
  logic                          host_mode_s;

  logic                          wr_pend_r;
  logic [5:0]                    wr_idx_r;
  logic                          wr_now;
  logic [7:0]                    wdat;
  logic                          addr_take;
  logic                          rd_take;
  logic [5:0]                    req_idx;
  logic                          req_mapped;

  logic [7:0]                    rise_en_r;
  logic [7:0]                    rise_en_nxt;
  logic [7:0]                    fall_en_r;
  logic [7:0]                    fall_en_nxt;
  logic [7:0]                    scratch_r;
  logic [7:0]                    scratch_nxt;
  logic [7:0]                    kit_ctrl_r;
  logic [7:0]                    kit_ctrl_nxt;
  logic [7:0]                    iface_r;
  logic [7:0]                    iface_nxt;
  logic [7:0]                    latch_r;
  logic [7:0]                    latch_nxt;
  logic [7:0]                    status_val;
  logic [7:0]                    debug_val;
  logic [7:0]                    rd_val;

  logic [31:0]                   hrdata_r;
  logic                          hreadyout_r;
  logic                          hresp_r;
  logic                          id_drive_r;
  logic                          dminus_out_r;
  logic                          dminus_oe_r;
  logic                          data1_out_r;
  logic                          data1_oe_r;

  // Pins from the analog side and the link are asynchronous to hclk
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= {dplus_in, data0_in, kit_exit_in, host_mode_in, line_state_in,
                   id_grounded, session_end_level, session_valid_level,
                   vbus_valid_in, host_detach_in};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign host_mode_s = pin_s2_r[pek_pkg::PIN_HOST_MODE];

  always_comb
  begin
    src_now = pin_s2_r[pek_pkg::SRC_COUNT-1:0];
    // Detach is only meaningful while acting as host
    src_now[pek_pkg::SRC_HOST_DETACH] = src_now[pek_pkg::SRC_HOST_DETACH] & host_mode_s;
  end

  // Previous level; reset to zero, so a source already high at release shows as a rising edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      src_prev_r <= '0;
    else
      src_prev_r <= src_now;
  end

  // Edge detect against enables; the detach event is masked by host mode too, so bit 0 is inert outside host mode
  always_comb
  begin
    events = (src_now & ~src_prev_r & rise_en_r[pek_pkg::SRC_COUNT-1:0])
           | (~src_now & src_prev_r & fall_en_r[pek_pkg::SRC_COUNT-1:0]);
    events[pek_pkg::SRC_HOST_DETACH] = events[pek_pkg::SRC_HOST_DETACH] & host_mode_s;
  end

  // Live views; the status reflects the comparators from the second clock edge after reset release, through the two sync stages
  assign status_val = {3'h0, src_now};
  assign debug_val  = {6'h00, pin_s2_r[pek_pkg::PIN_LINE1], pin_s2_r[pek_pkg::PIN_LINE0]};

  // Bus address phase
  assign req_idx    = haddr[7:2];
  assign req_mapped = (haddr[31:8] == 24'h000000);
  assign addr_take  = hsel & hready & htrans[1];
  assign rd_take    = addr_take & ~hwrite & req_mapped;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 6'h00;
    end
    else if (hready)
    begin
      wr_pend_r <= addr_take & hwrite & req_mapped;
      wr_idx_r  <= req_idx;
    end
  end

  assign wr_now = wr_pend_r;
  assign wdat   = hwdata[7:0];

  // Next values include the data phase write, so a read right behind it sees it
  always_comb
  begin
    rise_en_nxt  = rise_en_r;
    fall_en_nxt  = fall_en_r;
    scratch_nxt  = scratch_r;
    kit_ctrl_nxt = kit_ctrl_r;
    iface_nxt    = iface_r;
    if (wr_now)
    begin
      rise_en_nxt  = pek_apply(rise_en_r, wr_idx_r, pek_pkg::IDX_RISE_WR, wdat,
                               pek_pkg::MASK_ENABLE);
      fall_en_nxt  = pek_apply(fall_en_r, wr_idx_r, pek_pkg::IDX_FALL_WR, wdat,
                               pek_pkg::MASK_ENABLE);
      scratch_nxt  = pek_apply(scratch_r, wr_idx_r, pek_pkg::IDX_SCRATCH_WR, wdat,
                               pek_pkg::MASK_SCRATCH);
      kit_ctrl_nxt = pek_apply(kit_ctrl_r, wr_idx_r, pek_pkg::IDX_KIT_WR, wdat,
                               pek_pkg::MASK_KIT);
      iface_nxt    = pek_apply(iface_r, wr_idx_r, pek_pkg::IDX_IFACE_WR, wdat,
                               pek_pkg::MASK_IFACE);
    end
    // Leaving kit mode overrides any software write of the same cycle
    if (pin_s2_r[pek_pkg::PIN_KIT_EXIT])
      iface_nxt[pek_pkg::IFACE_KIT_MODE] = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rise_en_r <= pek_pkg::RST_ENABLE;
      fall_en_r <= pek_pkg::RST_ENABLE;
    end
    else
    begin
      rise_en_r <= rise_en_nxt;
      fall_en_r <= fall_en_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      scratch_r <= pek_pkg::RST_SCRATCH;
    else
      scratch_r <= scratch_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      kit_ctrl_r <= pek_pkg::RST_KIT;
      iface_r    <= pek_pkg::RST_IFACE;
    end
    else
    begin
      kit_ctrl_r <= kit_ctrl_nxt;
      iface_r    <= iface_nxt;
    end
  end

  // Read clears, but a fresh event of the same cycle lands after the clear
  always_comb
  begin
    latch_nxt = latch_r;
    if (rd_take && req_idx == pek_pkg::IDX_LATCH)
      latch_nxt = 8'h00;
    latch_nxt = latch_nxt | {3'h0, events};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      latch_r <= 8'h00;
    else
      latch_r <= latch_nxt;
  end

  // Read mux; every triple reads the same value at all three addresses
  always_comb
  begin
    rd_val = 8'h00;
    if (pek_in_triple(req_idx, pek_pkg::IDX_RISE_WR))
      rd_val = rise_en_nxt;
    else if (pek_in_triple(req_idx, pek_pkg::IDX_FALL_WR))
      rd_val = fall_en_nxt;
    else if (pek_in_triple(req_idx, pek_pkg::IDX_SCRATCH_WR))
      rd_val = scratch_nxt;
    else if (pek_in_triple(req_idx, pek_pkg::IDX_KIT_WR))
      rd_val = kit_ctrl_nxt;
    else if (pek_in_triple(req_idx, pek_pkg::IDX_IFACE_WR))
      rd_val = iface_nxt;
    else if (req_idx == pek_pkg::IDX_STATUS)
      rd_val = status_val;
    else if (req_idx == pek_pkg::IDX_LATCH)
      rd_val = latch_r;
    else if (req_idx == pek_pkg::IDX_DEBUG)
      rd_val = debug_val;
  end

  // Zero wait state: data is registered at the address phase edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= 32'h00000000;
    else if (rd_take)
      hrdata_r <= {24'h000000, rd_val};
    else if (hready)
      hrdata_r <= 32'h00000000;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
    else
    begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  // Pin drives; the route enables act on their own, the interface mode only gates line 1
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      id_drive_r   <= 1'b0;
      dminus_out_r <= 1'b0;
      dminus_oe_r  <= 1'b0;
      data1_out_r  <= 1'b1;
      data1_oe_r   <= 1'b0;
    end
    else
    begin
      id_drive_r   <= kit_ctrl_r[pek_pkg::KIT_ID_PULLDOWN];
      dminus_out_r <= pin_s2_r[pek_pkg::PIN_DATA0];
      dminus_oe_r  <= kit_ctrl_r[pek_pkg::KIT_TX_ROUTE];
      // Kit mode alone also enables line 1, which is then driven idle high while the receive route is unset
      data1_out_r  <= kit_ctrl_r[pek_pkg::KIT_RX_ROUTE] ?
                      pin_s2_r[pek_pkg::PIN_DPLUS] : 1'b1;
      data1_oe_r   <= kit_ctrl_r[pek_pkg::KIT_RX_ROUTE] |
                      iface_r[pek_pkg::IFACE_KIT_MODE];
    end
  end

  assign hrdata                = hrdata_r;
  assign hreadyout             = hreadyout_r;
  assign hresp                 = hresp_r;
  assign id_pin_pulldown_drive = id_drive_r;
  assign id_pin_out            = 1'b0;
  assign id_pin_oe             = id_drive_r;
  assign dminus_out            = dminus_out_r;
  assign dminus_oe             = dminus_oe_r;
  assign data1_out             = data1_out_r;
  assign data1_oe              = data1_oe_r;
  assign kit_interface_mode    = iface_r[pek_pkg::IFACE_KIT_MODE];

endmodule // pek_event_kit_regs

/* File: pek_event_kit_regs_sva.sv */
`timescale 1ns/1ns
module pek_event_kit_regs_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        host_detach_in,
  input wire logic        vbus_valid_in,
  input wire logic        session_valid_level,
  input wire logic        session_end_level,
  input wire logic        id_grounded,
  input wire logic        host_mode_in,
  input wire logic [1:0]  line_state_in,
  input wire logic        kit_exit_in,
  input wire logic        data0_in,
  input wire logic        id_pin_pulldown_drive,
  input wire logic        id_pin_out,
  input wire logic        id_pin_oe,
  input wire logic        dminus_out,
  input wire logic        dminus_oe,
  input wire logic        data1_out,
  input wire logic        data1_oe,
  input wire logic        kit_interface_mode
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       rd_take;
  logic [5:0] idx;
  logic [7:0] lv;
  assign idx = haddr[7:2];
  assign rd_take = hsel && hready && htrans[1] && !hwrite && (haddr[31:8] == 24'h0);
  assign lv = {line_state_in, host_mode_in, id_grounded, session_end_level,
               session_valid_level, vbus_valid_in, host_detach_in};
  AST_NO_WAIT: assert property (hreadyout && !hresp)
    else $error("slave stalled or answered with an error");
  AST_UPPER_ZERO: assert property (hrdata[31:8] == 24'h0)
    else $error("read data above the register byte not zero");
  // Inputs pass two sync stages, so they must hold three edges before the read
  AST_STATUS: assert property ($stable(lv)[*3] ##0 (rd_take && idx == 6'h13)
    |=> hrdata[7:0] == {3'h0, lv[4:1], lv[0] & lv[5]})
    else $error("status read does not show the live levels");
  AST_DEBUG: assert property ($stable(lv)[*3] ##0 (rd_take && idx == 6'h15)
    |=> hrdata[7:0] == {6'h0, lv[7:6]})
    else $error("debug read does not show the line state");
  AST_ID_DRIVE: assert property (id_pin_oe == id_pin_pulldown_drive && !id_pin_out)
    else $error("ID pin drive does not follow the pulldown bit");
  AST_RX_IDLE_HIGH: assert property (!data1_out |-> data1_oe)
    else $error("data line 1 low without the receive route");
  AST_DMINUS: assert property (dminus_oe && $past(dminus_oe, 3)
    |-> dminus_out == $past(data0_in, 3))
    else $error("D-minus does not carry transmit data");
  AST_KIT_EXIT: assert property (kit_exit_in[*4] |=> !kit_interface_mode)
    else $error("kit mode not cleared on exit");
endmodule // pek_event_kit_regs_sva
bind pek_event_kit_regs pek_event_kit_regs_sva u_sva (.*);

/* File: pek_link_model.sv */
`timescale 1ns/1ns
module pek_link_model (
  input  wire logic        hclk,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hung
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hung = 1'b0;
  end
  // One single word transfer; a stuck slave raises hung instead of waiting forever
  task automatic xfer(input logic [5:0] idx, input logic wr, input logic [7:0] wd,
                      output logic [7:0] rd);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 16);
    hung <= hung | (n >= 16);
    hsel <= 1'b0;
    htrans <= 2'h0;
    // Address phase signals are not held into the data phase
    haddr <= ~{24'h0, idx, 2'h0};
    hwrite <= ~wr;
    hwdata <= {24'h0, wd};
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 16);
    hung <= hung | (n >= 16);
    rd = hrdata[7:0];
    // Released data no longer shows the written value
    hwdata <= ~{24'h0, wd};
  endtask
endmodule // pek_link_model

/* File: pek_event_kit_regs_bench.sv */
`timescale 1ns/1ns
module pek_event_kit_regs_bench;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, hung;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, line_state_in;
  logic [2:0]  hsize;
  logic [4:0]  lvl;
  logic        host_mode_in, kit_exit_in, data0_in, dplus_in, id_pin_pulldown_drive;
  logic        id_pin_out, id_pin_oe, dminus_out, dminus_oe, data1_out, data1_oe;
  logic        kit_interface_mode;
  int          errors = 0;
  int          check_count = 0;
  logic [5:0]  base [4] = '{6'h0D, 6'h10, 6'h16, 6'h19};
  logic [7:0]  mask [4] = '{8'h1F, 8'h1F, 8'hFF, 8'h0E};
  logic [7:0]  rstv [4] = '{8'h1F, 8'h1F, 8'h00, 8'h00};

  pek_event_kit_regs DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .host_detach_in(lvl[0]),
    .vbus_valid_in(lvl[1]), .session_valid_level(lvl[2]), .session_end_level(lvl[3]),
    .id_grounded(lvl[4]), .host_mode_in(host_mode_in), .line_state_in(line_state_in),
    .kit_exit_in(kit_exit_in), .data0_in(data0_in), .dplus_in(dplus_in),
    .id_pin_pulldown_drive(id_pin_pulldown_drive), .id_pin_out(id_pin_out),
    .id_pin_oe(id_pin_oe), .dminus_out(dminus_out), .dminus_oe(dminus_oe),
    .data1_out(data1_out), .data1_oe(data1_oe), .kit_interface_mode(kit_interface_mode));
  pek_link_model LINK (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hung(hung));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [5:0] i, output logic [7:0] d);
    LINK.xfer(i, 1'b0, 8'h00, d);
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] v);
    logic [7:0] x;
    LINK.xfer(i, 1'b1, v, x);
  endtask
  // Covers two sync stages plus edge detect with margin
  task automatic settle;
    repeat (5) @(posedge hclk);
  endtask

  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    errors++;
    wrap_up;
  end
  always @(posedge hung)
  begin
    errors++;
    wrap_up;
  end

  initial
  begin
    logic [7:0] d, a, b, c;
    lvl = 5'h00;
    host_mode_in = 1'b1;
    line_state_in = 2'h2;
    kit_exit_in = 1'b0;
    data0_in = 1'b1;
    dplus_in = 1'b1;
    hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    settle;
    for (int i = 0; i < 3; i++)
    begin
      rd(6'h0D + 6'(i), d); chk(d, 8'h1F);
      rd(6'h10 + 6'(i), d); chk(d, 8'h1F);
      rd(6'h16 + 6'(i), d); chk(d, 8'h00);
      rd(6'h19 + 6'(i), d); chk(d, 8'h00);
    end
    rd(6'h13, d); chk(d, 8'h00);
    rd(6'h15, d); chk(d, 8'h02);
    wr(6'h14, 8'hFF);
    rd(6'h14, d); chk(d, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(base[i], 8'hFF);
      rd(base[i] + 6'h1, d); chk(d, mask[i]);
      wr(base[i] + 6'h2, 8'h0A);
      rd(base[i] + 6'h2, d); chk(d, mask[i] & 8'hF5);
      wr(base[i] + 6'h1, 8'h02);
      rd(base[i], d); chk(d, mask[i] & 8'hF7);
      wr(base[i], rstv[i]);
    end
    @(posedge hclk); lvl <= 5'h1F;
    settle;
    rd(6'h13, d); chk(d, 8'h1F);
    rd(6'h14, d); chk(d, 8'h1F);
    rd(6'h14, d); chk(d, 8'h00);
    wr(6'h12, 8'h04);
    @(posedge hclk); lvl <= 5'h00;
    settle;
    rd(6'h14, d); chk(d, 8'h1B);
    wr(6'h10, 8'h1F);
    @(posedge hclk); host_mode_in <= 1'b0;
    settle;
    rd(6'h14, d);
    @(posedge hclk); lvl <= 5'h01;
    settle;
    rd(6'h13, d); chk(d, 8'h00);
    rd(6'h14, d); chk(d, 8'h00);
    @(posedge hclk); lvl <= 5'h00; host_mode_in <= 1'b1;
    settle;
    rd(6'h14, d);
    // Sweep the read against the event so one read lands on the setting edge
    for (int n = 0; n < 5; n++)
    begin
      @(posedge hclk); lvl[1] <= ~lvl[1];
      repeat (n) @(posedge hclk);
      rd(6'h14, a); rd(6'h14, b); settle; rd(6'h14, c);
      chk({7'h0, a[1] ^ b[1] ^ c[1]}, 8'h01);
    end
    wr(6'h19, 8'h0C);
    wr(6'h08, 8'h04);
    rd(6'h07, d); chk(d, 8'h04);
    for (int v = 0; v < 2; v++)
    begin
      @(posedge hclk); dplus_in <= v[0]; data0_in <= ~v[0];
      settle;
      chk({6'h0, data1_oe, data1_out}, {6'h0, 1'b1, v[0]});
      chk({6'h0, dminus_oe, dminus_out}, {6'h0, 1'b1, ~v[0]});
    end
    wr(6'h1B, 8'h08);
    @(posedge hclk); dplus_in <= 1'b0;
    settle;
    chk({6'h0, data1_oe, data1_out}, 8'h03);
    @(posedge hclk); kit_exit_in <= 1'b1; dplus_in <= 1'b0;
    settle;
    rd(6'h09, d); chk(d, 8'h00);
    chk({7'h0, kit_interface_mode}, 8'h00);
    wr(6'h1B, 8'h08);
    settle;
    chk({7'h0, data1_out}, 8'h01);
    wr(6'h1A, 8'h03);
    rd(6'h19, d); chk(d, 8'h06);
    chk({6'h0, id_pin_oe, id_pin_pulldown_drive}, 8'h03);
    rd(6'h30, d); chk(d, 8'h00);
    chk({7'h0, hresp}, 8'h00);
    wrap_up;
  end
endmodule // pek_event_kit_regs_bench
